// ===== hw/lds_pkg.sv
package lds_pkg;
   localparam int DATA_W = 16;
   localparam int WORD_W = 17;
   localparam int QUAD_W = 64;
   localparam int SAMPLES_PER_LOAD = 4;
   localparam int FIFO_DEPTH = 8;
   localparam int PTR_W = 3;
   localparam int ADDR_W = 5;
   localparam int REG_W = 8;
   localparam int CNT_W = 6;

   // register offsets
   localparam logic [4:0] STATUS_ADDR = 5'h00;
   localparam logic [4:0] SYNC_A_ADDR = 5'h01;
   localparam logic [4:0] SW_SYNC_ADDR = 5'h03;
   localparam logic [4:0] SYNC_B_ADDR = 5'h05;
   localparam logic [4:0] SYNC_C_ADDR = 5'h06;
   localparam logic [4:0] RESTART_ADDR = 5'h08;
   localparam logic [4:0] SETTINGS_ADDR = 5'h0A;

   // field positions
   localparam int SET_BIAS_LSB = 0;
   localparam int SET_INV_BIT = 3;
   localparam int SET_DELAY_LSB = 4;
   localparam int RESTART_BIT = 0;
   localparam int SW_SEL_BIT = 0;
   localparam int SW_SYNC_BIT = 1;
   localparam int STAT_LOCK_BIT = 0;
   localparam int STAT_FIFO_ERR_BIT = 1;
   localparam int SYNC_A_FIFO_BIT = 0;
   localparam int SYNC_B_DIV_BIT = 0;
   localparam int SYNC_C_ERR_BIT = 0;

   // values after reset
   localparam logic [7:0] SETTINGS_RST = 8'h80;
   localparam logic [7:0] RESTART_RST = 8'h01;
   localparam logic [7:0] SW_SYNC_RST = 8'h00;
   localparam logic [7:0] SYNC_A_RST = 8'h01;
   localparam logic [7:0] SYNC_B_RST = 8'h01;
   localparam logic [7:0] SYNC_C_RST = 8'h01;

   // loop bias codes
   localparam logic [2:0] BIAS_MAX = 3'h3;
   localparam logic [2:0] BIAS_MID = 3'h0;
   localparam logic [2:0] BIAS_MIN = 3'h5;
   localparam logic [2:0] BIAS_FORBIDDEN = 3'h4;
   localparam logic [5:0] RANGE_SHORT = 6'h03;
   localparam logic [5:0] RANGE_MID = 6'h07;
   localparam logic [5:0] RANGE_LONG = 6'h0F;
   localparam logic [3:0] DELAY_CENTRE = 4'h8;

   localparam logic [3:0] LOCK_STABLE_COUNT = 4'h8;
   localparam logic [3:0] FIFO_START_LEVEL = 4'h4;

   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int LINK_PERIOD_NS = 160;
   localparam int SAMPLE_DIV_INT = LINK_PERIOD_NS / 2 / CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] SAMPLE_DIV = CNT_W'(SAMPLE_DIV_INT);

   typedef enum logic [1:0] {
      DLL_RESET = 2'h0,
      DLL_MEASURE = 2'h1,
      DLL_LOCKED = 2'h3,
      DLL_FAULT = 2'h2
   } lds_dll_state_type;

   function automatic logic [5:0] range_limit(input logic [2:0] bias);
      if (bias == BIAS_MAX) begin
         range_limit = RANGE_SHORT;
      end else if (bias == BIAS_MIN) begin
         range_limit = RANGE_LONG;
      end else begin
         range_limit = RANGE_MID;
      end
   endfunction

   // sampling tap: half of the interval shifted by the delay code, plus one
   // whole interval more when the loop clock is inverted
   function automatic logic [5:0] sample_tap(input logic [5:0] half, input logic [3:0] code,
                                             input logic inv);
      logic [6:0] t;
      t = {2'h0, half[5:1]} + {3'h0, code};
      t = (t > {3'h0, DELAY_CENTRE}) ? t - {3'h0, DELAY_CENTRE} : 7'h00;
      if (inv) begin
         t = t + {1'b0, half};
      end
      sample_tap = (t > 7'h3F) ? 6'h3F : t[5:0];
   endfunction
endpackage

// ===== hw/lds_link_if.sv
`timescale 1ns/100ps
interface lds_link_if;
   logic capture_clock;
   logic [15:0] data;
   logic sync_line_positive;

   modport device (input capture_clock, input data, input sync_line_positive);
   modport source (output capture_clock, output data, output sync_line_positive);
endinterface

// ===== hw/lds_dev.sv
`timescale 1ns/100ps
module lds_dev (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   lds_link_if.device link,
   input wire logic [4:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   output logic [15:0] sample_out,
   output logic sample_valid_out,
   output logic transmit_gate_out,
   output logic sync_event_out
);
   logic [7:0] settings, restart, sw_ctrl, sync_a, sync_b, sync_c, rdata;
   logic [7:0] next_settings, next_restart, next_sw_ctrl, next_sync_a, next_sync_b;
   logic [7:0] next_sync_c, next_rdata;
   logic clk_m, clk_s, clk_d, sync_m, sync_s;
   logic [15:0] data_m, data_s;
   lds_pkg::lds_dll_state_type state, next_state;
   logic [5:0] cnt, next_cnt, half, next_half, wait_cnt, next_wait_cnt;
   logic [3:0] stable, next_stable;
   logic pending, next_pending, lock, next_lock;
   logic [16:0] mem [lds_pkg::FIFO_DEPTH];
   logic [3:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic running, next_running, fifo_err, next_fifo_err, prev_sync, next_prev_sync;
   logic [5:0] tick_cnt, next_tick_cnt;
   logic [15:0] next_sample;
   logic next_valid, next_gate, next_event;
   logic edge_seen, wr_en, rd_en, tick, eff_sync, rise;
   logic [3:0] level;
   logic [5:0] tap;

   // link pins pass two flops before any logic looks at them
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         clk_m <= 1'b0;
         clk_s <= 1'b0;
         clk_d <= 1'b0;
         data_m <= 16'h0000;
         data_s <= 16'h0000;
         sync_m <= 1'b0;
         sync_s <= 1'b0;
      end else begin
         clk_m <= link.capture_clock;
         clk_s <= clk_m;
         clk_d <= clk_s;
         data_m <= link.data;
         data_s <= data_m;
         sync_m <= link.sync_line_positive;
         sync_s <= sync_m;
      end
   end

   // both edges of the capture clock mark a new sample
   assign edge_seen = clk_s ^ clk_d;
   assign tap = lds_pkg::sample_tap(half, settings[lds_pkg::SET_DELAY_LSB +: 4],
                                    settings[lds_pkg::SET_INV_BIT]);

   // software register port
   always_comb begin
      next_settings = settings;
      next_restart = restart;
      next_sw_ctrl = sw_ctrl;
      next_sync_a = sync_a;
      next_sync_b = sync_b;
      next_sync_c = sync_c;
      next_rdata = 8'h00;
      if (reg_wr_in) begin
         if (reg_addr_in == lds_pkg::SETTINGS_ADDR) begin
            next_settings = reg_wdata_in;
         end else if (reg_addr_in == lds_pkg::RESTART_ADDR) begin
            next_restart = reg_wdata_in;
         end else if (reg_addr_in == lds_pkg::SW_SYNC_ADDR) begin
            next_sw_ctrl = reg_wdata_in;
         end else if (reg_addr_in == lds_pkg::SYNC_A_ADDR) begin
            next_sync_a = reg_wdata_in;
         end else if (reg_addr_in == lds_pkg::SYNC_B_ADDR) begin
            next_sync_b = reg_wdata_in;
         end else if (reg_addr_in == lds_pkg::SYNC_C_ADDR) begin
            next_sync_c = reg_wdata_in;
         end
      end
      if (reg_rd_in) begin
         if (reg_addr_in == lds_pkg::STATUS_ADDR) begin
            next_rdata[lds_pkg::STAT_LOCK_BIT] = lock;
            next_rdata[lds_pkg::STAT_FIFO_ERR_BIT] = fifo_err;
         end else if (reg_addr_in == lds_pkg::SETTINGS_ADDR) begin
            next_rdata = settings;
         end else if (reg_addr_in == lds_pkg::RESTART_ADDR) begin
            next_rdata = restart;
         end else if (reg_addr_in == lds_pkg::SW_SYNC_ADDR) begin
            next_rdata = sw_ctrl;
         end else if (reg_addr_in == lds_pkg::SYNC_A_ADDR) begin
            next_rdata = sync_a;
         end else if (reg_addr_in == lds_pkg::SYNC_B_ADDR) begin
            next_rdata = sync_b;
         end else if (reg_addr_in == lds_pkg::SYNC_C_ADDR) begin
            next_rdata = sync_c;
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         settings <= lds_pkg::SETTINGS_RST;
         restart <= lds_pkg::RESTART_RST;
         sw_ctrl <= lds_pkg::SW_SYNC_RST;
         sync_a <= lds_pkg::SYNC_A_RST;
         sync_b <= lds_pkg::SYNC_B_RST;
         sync_c <= lds_pkg::SYNC_C_RST;
         rdata <= 8'h00;
      end else begin
         settings <= next_settings;
         restart <= next_restart;
         sw_ctrl <= next_sw_ctrl;
         sync_a <= next_sync_a;
         sync_b <= next_sync_b;
         sync_c <= next_sync_c;
         rdata <= next_rdata;
      end
   end

   // delay loop: measures the sample interval, locks once it stays steady and the sampling tap is within the bias range limit
   always_comb begin
      next_state = state;
      next_cnt = (cnt == 6'h3F) ? cnt : cnt + 6'h01;
      next_half = half;
      next_stable = stable;
      next_lock = 1'b0;
      next_pending = pending;
      next_wait_cnt = wait_cnt;
      wr_en = 1'b0;
      if (edge_seen) begin
         next_cnt = 6'h00;
      end
      case (state)
         lds_pkg::DLL_RESET: begin
            next_stable = 4'h0;
            next_pending = 1'b0;
            if (!restart[lds_pkg::RESTART_BIT]) begin
               next_state = (settings[2:0] == lds_pkg::BIAS_FORBIDDEN) ? lds_pkg::DLL_FAULT
                            : lds_pkg::DLL_MEASURE;
            end
         end
         lds_pkg::DLL_MEASURE: begin
            if (edge_seen) begin
               if (cnt + 6'h01 == half) begin
                  next_stable = stable + 4'h1;
               end else begin
                  next_half = cnt + 6'h01;
                  next_stable = 4'h0;
               end
               if (stable == lds_pkg::LOCK_STABLE_COUNT
                   && tap <= lds_pkg::range_limit(settings[2:0])) begin
                  next_state = lds_pkg::DLL_LOCKED;
               end
            end
         end
         lds_pkg::DLL_LOCKED: begin
            next_lock = 1'b1;
            if (edge_seen) begin
               if (cnt + 6'h01 != half) begin
                  next_state = lds_pkg::DLL_MEASURE;
                  next_lock = 1'b0;
                  next_stable = 4'h0;
                  next_half = cnt + 6'h01;
               end else begin
                  next_pending = 1'b1;
                  next_wait_cnt = tap;
               end
            end
         end
         lds_pkg::DLL_FAULT: begin
            next_stable = 4'h0;
         end
         default: begin
            next_state = lds_pkg::DLL_RESET;
         end
      endcase
      if (pending && !(edge_seen && state == lds_pkg::DLL_LOCKED)) begin
         if (wait_cnt == 6'h00) begin
            wr_en = 1'b1;
            next_pending = 1'b0;
         end else begin
            next_wait_cnt = wait_cnt - 6'h01;
         end
      end
      if (restart[lds_pkg::RESTART_BIT]) begin
         next_state = lds_pkg::DLL_RESET;
         next_lock = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= lds_pkg::DLL_RESET;
         cnt <= 6'h00;
         half <= 6'h00;
         stable <= 4'h0;
         lock <= 1'b0;
         pending <= 1'b0;
         wait_cnt <= 6'h00;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         half <= next_half;
         stable <= next_stable;
         lock <= next_lock;
         pending <= next_pending;
         wait_cnt <= next_wait_cnt;
      end
   end

   // elastic queue drained at the measured sample rate
   assign level = wr_ptr - rd_ptr;
   assign tick = (tick_cnt == 6'h00) && (half != 6'h00);
   assign rd_en = tick && running && (level != 4'h0);
   assign eff_sync = sw_ctrl[lds_pkg::SW_SEL_BIT] ? sw_ctrl[lds_pkg::SW_SYNC_BIT]
                     : mem[rd_ptr[2:0]][16];
   assign rise = rd_en && eff_sync && !prev_sync;

   always_comb begin
      next_wr_ptr = wr_en ? wr_ptr + 4'h1 : wr_ptr;
      next_rd_ptr = rd_en ? rd_ptr + 4'h1 : rd_ptr;
      next_running = running;
      next_fifo_err = fifo_err;
      next_tick_cnt = (tick_cnt == 6'h00) ? half - 6'h01 : tick_cnt - 6'h01;
      next_prev_sync = rd_en ? eff_sync : prev_sync;
      next_sample = 16'h0000;
      next_valid = rd_en;
      next_gate = rd_en ? eff_sync : transmit_gate_out;
      next_event = rise;
      if (!running && level >= lds_pkg::FIFO_START_LEVEL) begin
         next_running = 1'b1;
      end
      if (rd_en && eff_sync) begin
         next_sample = mem[rd_ptr[2:0]][15:0];
      end
      if (rise && sync_c[lds_pkg::SYNC_C_ERR_BIT]) begin
         next_fifo_err = 1'b0;
      end
      if (rise && sync_a[lds_pkg::SYNC_A_FIFO_BIT]) begin
         next_rd_ptr = next_wr_ptr - lds_pkg::FIFO_START_LEVEL;
      end
      if (rise && sync_b[lds_pkg::SYNC_B_DIV_BIT]) begin
         next_tick_cnt = half - 6'h01;
      end
      if (tick && running && level == 4'h0) begin
         next_running = 1'b0;
         next_fifo_err = 1'b1;
      end
      if (wr_en && level == 4'(lds_pkg::FIFO_DEPTH)) begin
         next_fifo_err = 1'b1;
         next_rd_ptr = rd_ptr + 4'h1;
      end
      if (state != lds_pkg::DLL_LOCKED) begin
         next_running = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (wr_en) begin
         mem[wr_ptr[2:0]] <= {sync_s, data_s};
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wr_ptr <= 4'h0;
         rd_ptr <= 4'h0;
         running <= 1'b0;
         fifo_err <= 1'b0;
         tick_cnt <= 6'h00;
         prev_sync <= 1'b0;
         sample_out <= 16'h0000;
         sample_valid_out <= 1'b0;
         transmit_gate_out <= 1'b0;
         sync_event_out <= 1'b0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         running <= next_running;
         fifo_err <= next_fifo_err;
         tick_cnt <= next_tick_cnt;
         prev_sync <= next_prev_sync;
         sample_out <= next_sample;
         sample_valid_out <= next_valid;
         transmit_gate_out <= next_gate;
         sync_event_out <= next_event;
      end
   end

   assign reg_rdata_out = rdata;
endmodule

// ===== hw/lds_src.sv
`timescale 1ns/100ps
module lds_src (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   lds_link_if.source link,
   input wire logic [63:0] quad_in,
   input wire logic quad_valid_in,
   input wire logic sync_in,
   output logic quad_ready_out
);
   logic [5:0] div_cnt, next_div_cnt;
   logic [63:0] shift, next_shift;
   logic [2:0] left, next_left;
   logic clk_q, next_clk_q, sync_q, next_sync_q, ready, next_ready;
   logic [15:0] data_q, next_data_q;
   logic tick, load;

   assign tick = (div_cnt == 6'h00);
   assign load = quad_valid_in && ready;

   always_comb begin
      next_div_cnt = tick ? lds_pkg::SAMPLE_DIV - 6'h01 : div_cnt - 6'h01;
      next_shift = shift;
      next_left = left;
      next_clk_q = clk_q;
      next_sync_q = sync_q;
      next_data_q = data_q;
      // the clock lane toggles on every tick, a load never holds it back
      if (tick) begin
         next_clk_q = !clk_q;
         next_sync_q = sync_in;
         if (left != 3'h0) begin
            next_data_q = shift[15:0];
            next_shift = {16'h0000, shift[63:16]};
            next_left = left - 3'h1;
         end else begin
            next_data_q = 16'h0000;
         end
      end
      if (load) begin
         next_shift = quad_in;
         next_left = 3'(lds_pkg::SAMPLES_PER_LOAD);
      end
      next_ready = (next_left == 3'h0);
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         div_cnt <= 6'h00;
         shift <= 64'h0000000000000000;
         left <= 3'h0;
         clk_q <= 1'b0;
         sync_q <= 1'b0;
         data_q <= 16'h0000;
         ready <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         shift <= next_shift;
         left <= next_left;
         clk_q <= next_clk_q;
         sync_q <= next_sync_q;
         data_q <= next_data_q;
         ready <= next_ready;
      end
   end

   // eighteen lanes: clock, sync and sixteen data bits
   assign link.capture_clock = clk_q;
   assign link.data = data_q;
   assign link.sync_line_positive = sync_q;
   assign quad_ready_out = ready;
endmodule

// ===== verif/lds_properties.sv
`timescale 1ns/100ps
module lds_properties (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic capture_clock,
   input wire logic [15:0] data,
   input wire logic sync_line_positive
);
   logic [2:0] gap;
   logic [2:0] next_gap;
   logic prev_clock;

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (sys_rst_in);

   // cycles since the capture clock last moved
   always_comb begin
      if (capture_clock != prev_clock) begin
         next_gap = 3'h0;
      end else if (gap == 3'h7) begin
         next_gap = gap;
      end else begin
         next_gap = gap + 3'h1;
      end
   end
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         gap <= 3'h0;
         prev_clock <= 1'b0;
      end else begin
         gap <= next_gap;
         prev_clock <= capture_clock;
      end
   end

   a_tick_period: assert property ($changed(capture_clock) |-> ##4 $changed(capture_clock))
      else $error("capture clock period wrong");
   a_tick_hold: assert property ($changed(capture_clock) |=> $stable(capture_clock)[*3])
      else $error("capture clock moved early");
   a_data_on_edge: assert property ($changed(data) |-> $changed(capture_clock))
      else $error("data moved without clock edge");
   a_sync_on_edge: assert property ($changed(sync_line_positive) |-> $changed(capture_clock))
      else $error("sync moved without clock edge");
   a_lanes_hold: assert property ($changed(capture_clock) |=>
         ($stable(data) && $stable(sync_line_positive))[*3])
      else $error("lanes not held between edges");
   a_clock_runs: assert property (gap <= 3'h3)
      else $error("capture clock stalled");
   a_rise_then_fall: assert property ($rose(capture_clock) |-> ##4 $fell(capture_clock))
      else $error("no falling edge after rising");
   a_fall_then_rise: assert property ($fell(capture_clock) |-> ##4 $rose(capture_clock))
      else $error("no rising edge after falling");

   c_clock_rise: cover property ($rose(capture_clock));
   c_data_moves: cover property ($changed(data));
   c_sync_rise: cover property ($rose(sync_line_positive));
endmodule

// ===== verif/lds_bench.sv
`timescale 1ns/100ps
module lds_bench;
   logic clk_sys_in;
   logic sys_rst_in;
   logic [4:0] reg_addr_in;
   logic [7:0] reg_wdata_in;
   logic reg_wr_in;
   logic reg_rd_in;
   logic [7:0] reg_rdata_out;
   logic [15:0] sample_out;
   logic sample_valid_out;
   logic transmit_gate_out;
   logic sync_event_out;
   logic [63:0] quad_in;
   logic quad_valid_in;
   logic sync_in;
   logic quad_ready_out;
   int failures;
   int n_tests;
   int cycles;
   int events;
   logic [15:0] got[$];

   lds_link_if u_lds_link_if ();

   lds_dev u_lds_dev (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .link(u_lds_link_if),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .sample_out(sample_out),
      .sample_valid_out(sample_valid_out), .transmit_gate_out(transmit_gate_out),
      .sync_event_out(sync_event_out));

   lds_src u_lds_src (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .link(u_lds_link_if),
      .quad_in(quad_in), .quad_valid_in(quad_valid_in), .sync_in(sync_in),
      .quad_ready_out(quad_ready_out));

   lds_properties u_lds_properties (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .capture_clock(u_lds_link_if.capture_clock), .data(u_lds_link_if.data),
      .sync_line_positive(u_lds_link_if.sync_line_positive));

   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end

   // collects gated samples and counts sync events
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (sample_valid_out === 1'b1 && sample_out !== 16'h0000) begin
         got.push_back(sample_out);
      end
      if (sync_event_out === 1'b1) begin
         events <= events + 1;
      end
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      // read data stand in the cycle after the strobe; take them at its closing edge
      @(posedge clk_sys_in);
      d = reg_rdata_out;
   endtask

   task automatic reg_defaults();
      logic [7:0] v;
      logic [4:0] adr[7] = '{5'h01, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0A, 5'h1F};
      logic [7:0] exp[7] = '{lds_pkg::SYNC_A_RST, lds_pkg::SW_SYNC_RST, lds_pkg::SYNC_B_RST,
         lds_pkg::SYNC_C_RST, lds_pkg::RESTART_RST, lds_pkg::SETTINGS_RST, 8'h00};
      for (int i = 0; i < 7; i++) begin
         rd(adr[i], v);
         check({8'h00, v}, {8'h00, exp[i]});
      end
      wr(5'h1F, 8'hFF);
      rd(5'h1F, v);
      check({8'h00, v}, 16'h0000);
      wr(lds_pkg::STATUS_ADDR, 8'hFF);
      rd(lds_pkg::STATUS_ADDR, v);
      check({15'h0000, v[0]}, 16'h0000);
   endtask

   // restart the loop with the given settings and judge lock
   task automatic lock_try(input logic [7:0] set, input logic exp);
      logic [7:0] v;
      wr(lds_pkg::RESTART_ADDR, 8'h01);
      wr(lds_pkg::SETTINGS_ADDR, set);
      rd(lds_pkg::SETTINGS_ADDR, v);
      check({8'h00, v}, {8'h00, set});
      rd(lds_pkg::STATUS_ADDR, v);
      check({15'h0000, v[0]}, 16'h0000);
      wr(lds_pkg::RESTART_ADDR, 8'h00);
      for (int k = 0; k < 60; k++) begin
         rd(lds_pkg::STATUS_ADDR, v);
         if (v[0] === 1'b1) begin
            break;
         end
      end
      check({15'h0000, v[0]}, {15'h0000, exp});
   endtask

   task automatic send(input logic [63:0] q);
      quad_in <= q;
      quad_valid_in <= 1'b1;
      // valid and data stand until the edge at which ready is sampled high
      for (int k = 0; k < 100; k++) begin
         @(posedge clk_sys_in);
         if (quad_ready_out === 1'b1) begin
            break;
         end
      end
   endtask

   task automatic stream(input logic [15:0] base);
      for (int j = 0; j < 3; j++) begin
         send({base + 16'(4 * j + 3), base + 16'(4 * j + 2), base + 16'(4 * j + 1),
            base + 16'(4 * j)});
      end
      quad_valid_in <= 1'b0;
      repeat (150) @(posedge clk_sys_in);
   endtask

   task automatic data_flow();
      int e;
      got.delete();
      e = events;
      sync_in <= 1'b1;
      // the sync bit must pass a possibly full queue before it is read
      repeat (80) @(posedge clk_sys_in);
      check(16'(events - e), 16'h0001);
      stream(16'h1001);
      check(16'(got.size()), 16'h000C);
      for (int i = 0; i < got.size(); i++) begin
         check(got[i], 16'h1001 + 16'(i));
      end
      check({15'h0000, transmit_gate_out}, 16'h0001);
   endtask

   task automatic sync_gating();
      int e;
      sync_in <= 1'b0;
      repeat (40) @(posedge clk_sys_in);
      got.delete();
      stream(16'h2001);
      check(16'(got.size()), 16'h0000);
      check({15'h0000, transmit_gate_out}, 16'h0000);
      e = events;
      wr(lds_pkg::SW_SYNC_ADDR, 8'h03);
      repeat (60) @(posedge clk_sys_in);
      check({15'h0000, transmit_gate_out}, 16'h0001);
      check(16'(events - e), 16'h0001);
      wr(lds_pkg::SW_SYNC_ADDR, 8'h01);
      repeat (60) @(posedge clk_sys_in);
      check({15'h0000, transmit_gate_out}, 16'h0000);
   endtask

   initial begin
      failures = 0;
      n_tests = 0;
      cycles = 0;
      events = 0;
      sys_rst_in = 1'b1;
      reg_addr_in = 5'h00;
      reg_wdata_in = 8'h00;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      quad_in = 64'h0;
      quad_valid_in = 1'b0;
      sync_in = 1'b0;
      repeat (8) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      reg_defaults();
      lock_try(8'h84, 1'b0);
      lock_try(8'hF3, 1'b0);
      lock_try(8'h83, 1'b1);
      lock_try(8'hF5, 1'b1);
      lock_try(8'h88, 1'b1);
      lock_try(8'h80, 1'b1);
      data_flow();
      sync_gating();
      conclude();
   end
endmodule
